// [hdl/mlc_pkg.sv]
// package: constants, register map and carrier types of the light control
package mlc_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ  = 100;
  localparam int TICK_MS  = 100;  // unit of every configured time
  localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
  localparam int TICK_W   = 24;

  // ==========================================================================
  // register indices (byte address = 4 * index)
  localparam int NCFG    = 10;
  localparam int R_CTRL  = 0;
  localparam int R_SETP  = 1;
  localparam int R_HYST  = 2;
  localparam int R_START = 3;
  localparam int R_WAIT  = 4;
  localparam int R_MAIN  = 5;
  localparam int R_CH2   = 6;
  localparam int R_CH3   = 7;
  localparam int R_ONOFF = 8;
  localparam int R_RANGE = 9;
  localparam int R_STAT  = 10;
  localparam int R_MEAS  = 11;

  // ==========================================================================
  // field positions
  localparam int CT_EN   = 0;   // enable control
  localparam int CT_NCH  = 1;   // channels in use, 2 bits, 1..3
  localparam int CT_SU   = 3;   // startup behaviour, 2 bits
  localparam int CT_REL  = 5;   // main phase uses relative dimming, one channel only
  localparam int CT_DECR = 6;   // decreasing offset method
  localparam int CT_LLEN = 7;   // evaluate lower output limit
  localparam int CT_OFF  = 8;   // switch off at switch-off brightness once at the lower limit, needs CT_LLEN
  localparam int HY_SP   = 0;   // setpoint hysteresis, percent
  localparam int HY_ADD  = 8;   // additional switch-off hysteresis
  localparam int SU_FIX  = 0;   // fixed startup value
  localparam int SU_STEP = 8;   // startup dim step code, 3 bits
  localparam int SU_REP  = 16;  // startup repeat, ticks
  localparam int MN_ABS  = 0;   // minimum absolute change
  localparam int MN_REP  = 8;   // minimum repeat time, ticks
  localparam int MN_LL   = 16;  // lower output limit
  localparam int MN_REL  = 24;  // minimum relative step code, 3 bits
  localparam int CH_PCT  = 0;   // percentage
  localparam int CH_SOFF = 8;   // signed start offset
  localparam int CH_SYNC = 16;  // synchronization output of channel 1

  localparam logic [NCFG-1:0][31:0] CFG_MASK = {
    32'h0000ffff, 32'h000000ff, 32'h00ffffff, 32'h00ffffff,
    32'h07ffffff, 32'h0000ffff, 32'h00ff07ff, 32'h0000ffff,
    32'h0000ffff, 32'h000001ff};
  localparam logic [NCFG-1:0][31:0] CFG_RST = {
    32'h00000000, 32'h00000000, 32'h00000064, 32'h00000064,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000002};

  // ==========================================================================
  // arithmetic constants
  localparam int PCT_FULL = 100;
  localparam int PCT_HALF = 50;
  localparam int OUT_MAX  = 255;
  localparam int LL_MIN   = 1;
  localparam int LL_MAX   = 128;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    PH_IDLE, PH_EVAL, PH_SDIM, PH_WAIT, PH_MAIN, PH_OFF
  } mlc_phase_t;
  typedef enum logic [1:0] {
    SU_SWITCH, SU_DIM, SU_FIXED, SU_ADAPT
  } mlc_su_t;
  typedef enum logic [1:0] {TK_SWITCH, TK_DIM, TK_VALUE} mlc_kind_t;

  typedef struct packed {
    logic        valid;
    mlc_kind_t   kind;
    logic [2:0]  chans;
    logic        on;
    logic [3:0]  dim;
    logic [7:0]  v1;
    logic [7:0]  v2;
    logic [7:0]  v3;
  } mlc_tel_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writedata;
  } mlc_avs_t;

  typedef struct packed {
    logic       on;
    logic [7:0] offat;
    logic [7:0] out;
  } mlc_der_t;

endpackage : mlc_pkg

// [hdl/mlc_ctrl.sv]
// multichannel constant-light controller with avalon register slave
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
// ============================================================================
module mlc_ctrl #(
  parameter int TICK_CYCLES = mlc_pkg::TICK_CYC
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire mlc_pkg::mlc_avs_t avs_req,
  output logic                  avs_waitrequest,
  output logic [31:0]           avs_readdata,
  input  wire logic [15:0]      brightness,
  output mlc_pkg::mlc_tel_t     tel
);
  import mlc_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    mlc_phase_t                phase;
    logic                      waitreq;
    logic [31:0]               rdata;
    logic [NCFG-1:0][31:0]     cfg;
    logic [7:0]                c1;
    mlc_der_t                  d2;
    mlc_der_t                  d3;
    logic [TICK_W-1:0]         tick;
    logic [15:0]               timer;
    mlc_tel_t                  tel;
  } mlc_st_t;

  mlc_st_t r_reg;
  mlc_st_t r_next;

  // ==========================================================================
  // derived channel output
  function automatic mlc_der_t derive(
    input logic [7:0]  c1,
    input logic        decr,
    input logic [31:0] cc,
    input logic [7:0]  hy,
    input mlc_der_t    p
  );
    logic [16:0]       pr;
    logic [16:0]       q;
    logic [7:0]        soff;
    logic [7:0]        sm;
    logic [7:0]        sync;
    logic [7:0]        den;
    logic [15:0]       mg;
    logic [7:0]        o;
    logic signed [9:0] raw;
    mlc_der_t          d;
    pr   = '0;
    q    = '0;
    soff = cc[CH_SOFF +: 8];
    sync = cc[CH_SYNC +: 8];
    sm   = soff[7] ? 8'(-soff) : soff;
    den  = 8'(sync - 8'h01);
    mg   = '0;
    o    = '0;
    d    = p;
    if (!decr) begin
      pr  = 17'(c1 * cc[CH_PCT +: 8]) + 17'(PCT_HALF);
      q   = pr / 17'(PCT_FULL);
      raw = (q > 17'(OUT_MAX)) ? 10'sd255 :
            $signed({2'b00, q[7:0]});
    end else if (sync <= c1 || sync < 8'h02) begin
      raw = $signed({2'b00, c1});
    end else begin
      mg  = 16'((sync - c1) * sm) + 16'(den >> 1);
      o   = 8'(mg / 16'(den));
      raw = soff[7] ? $signed({2'b00, c1}) - $signed({2'b00, o})
                    : $signed({2'b00, c1}) + $signed({2'b00, o});
    end
    if (c1 == 8'h00) begin
      d.on = 1'b0;
    end else if (p.on && raw <= 10'sd0) begin
      d.on    = 1'b0;
      d.offat = c1;
    end else if (!p.on && raw > 10'sd0 &&
                 {1'b0, c1} >= {1'b0, p.offat} + {1'b0, hy}) begin
      d.on = 1'b1;
    end
    if (!d.on) d.out = 8'h00;
    else if (raw > 10'sd255) d.out = 8'hff;
    else d.out = raw[7:0];
    return d;
  endfunction : derive

  // ==========================================================================
  // configuration views
  logic [31:0] ctrl;
  logic [15:0] setp;
  logic [7:0]  hy_sp;
  logic [7:0]  hy_add;
  logic [31:0] sreg;
  logic [31:0] mreg;
  logic [1:0]  nch;
  logic        multi;
  mlc_su_t     su;
  logic [7:0]  llim;
  logic [24:0] p_sp;
  logic [24:0] p_off;
  logic [16:0] band;
  logic [16:0] lo;
  logic [16:0] hi;
  logic [17:0] offb;

  assign ctrl   = r_reg.cfg[R_CTRL];
  assign setp   = r_reg.cfg[R_SETP][15:0];
  assign hy_sp  = r_reg.cfg[R_HYST][HY_SP +: 8];
  assign hy_add = r_reg.cfg[R_HYST][HY_ADD +: 8];
  assign sreg   = r_reg.cfg[R_START];
  assign mreg   = r_reg.cfg[R_MAIN];
  assign nch    = ctrl[CT_NCH +: 2];
  assign multi  = nch > 2'd1;
  assign su     = mlc_su_t'(ctrl[CT_SU +: 2]);
  // lower limit forced into its legal span
  assign llim   = (mreg[MN_LL +: 8] < 8'(LL_MIN)) ? 8'(LL_MIN) :
                  (mreg[MN_LL +: 8] > 8'(LL_MAX)) ? 8'(LL_MAX) :
                  mreg[MN_LL +: 8];
  assign p_sp   = 25'(setp * hy_sp);
  assign p_off  = 25'(setp * ({1'b0, hy_sp} + {1'b0, hy_add}));
  assign band   = 17'(p_sp / 25'(PCT_FULL));
  assign lo     = ({1'b0, setp} > band) ? {1'b0, setp} - band : '0;
  assign hi     = {1'b0, setp} + band;
  assign offb   = {2'b00, setp} + 18'(p_off / 25'(PCT_FULL));

  // ==========================================================================
  // next state
  logic              req;
  logic [3:0]        idx;
  logic              tk;
  logic              tmo;
  logic [7:0]        c1n;
  logic              send_val;
  logic [7:0]        astep;
  logic [7:0]        rstep;
  logic [7:0]        step;
  logic [7:0]        floor_v;
  logic [23:0]       adapt;
  logic [15:0]       rng;
  logic [2:0]        chmask;
  mlc_der_t          n2;
  mlc_der_t          n3;

  always_comb begin
    r_next          = r_reg;
    r_next.tel.valid = 1'b0;
    req      = avs_req.read | avs_req.write;
    idx      = avs_req.address[5:2];
    c1n      = r_reg.c1;
    send_val = 1'b0;
    chmask   = multi ? ((nch == 2'd2) ? 3'b011 : 3'b111) : 3'b001;
    astep    = (mreg[MN_ABS +: 8] == 8'h00) ? 8'h01 : mreg[MN_ABS +: 8];
    rstep    = 8'(OUT_MAX) >> (mreg[MN_REL +: 3] - 3'd1);
    step     = (ctrl[CT_REL] && !multi) ? rstep : astep;
    floor_v  = ctrl[CT_LLEN] ? llim : 8'h01;
    rng      = r_reg.cfg[R_RANGE][15:0];
    adapt    = '0;
    // ---- avalon slave: one wait state, write lands when waitrequest low
    r_next.waitreq = !(req && r_reg.waitreq);
    if (req && r_reg.waitreq) begin
      r_next.rdata = 32'h00000000;
      if (avs_req.address[1:0] == 2'b00) begin
        if (int'(idx) < NCFG) r_next.rdata = r_reg.cfg[idx];
        else if (int'(idx) == R_STAT)
          r_next.rdata = {5'h00, r_reg.phase, r_reg.d3.out,
                          r_reg.d2.out, r_reg.c1};
        else if (int'(idx) == R_MEAS) r_next.rdata = {16'h0000, brightness};
      end
    end
    if (avs_req.write && !r_reg.waitreq && avs_req.address[1:0] == 2'b00 &&
        int'(idx) < NCFG)
      r_next.cfg[idx] = avs_req.writedata & CFG_MASK[idx];
    // ---- timebase
    tk          = r_reg.tick == TICK_W'(TICK_CYCLES - 1);
    r_next.tick = tk ? '0 : r_reg.tick + 1'b1;
    if (tk && r_reg.timer != 16'h0000) r_next.timer = r_reg.timer - 1'b1;
    tmo = r_reg.timer == 16'h0000;
    // ---- phase sequencing
    unique case (r_reg.phase)
      PH_IDLE: begin
        if (ctrl[CT_EN]) r_next.phase = PH_EVAL;
      end
      PH_EVAL: begin
        r_next.timer = r_reg.cfg[R_WAIT][15:0];
        r_next.phase = PH_WAIT;
        if (brightness >= setp) begin
          r_next.phase = PH_MAIN;
          r_next.timer = '0;
        end else if (su == SU_SWITCH && !multi) begin
          r_next.tel.valid = 1'b1;
          r_next.tel.kind  = TK_SWITCH;
          r_next.tel.on    = 1'b1;
          r_next.tel.chans = 3'b001;
          c1n = 8'(OUT_MAX);
        end else if (su == SU_DIM && !multi) begin
          r_next.tel.valid = 1'b1;
          r_next.tel.kind  = TK_DIM;
          r_next.tel.dim   = {1'b1, sreg[SU_STEP +: 3]};
          r_next.tel.chans = 3'b001;
          r_next.timer     = 16'(sreg[SU_REP +: 8]);
          r_next.phase     = PH_SDIM;
        end else if (su == SU_ADAPT) begin
          // no range configured: assume full output is needed
          adapt = (rng == 16'h0000) ? 24'(OUT_MAX) :
                  (24'(OUT_MAX) * 24'(setp - brightness) + 24'(rng >> 1))
                  / 24'(rng);
          c1n = (adapt > 24'(OUT_MAX)) ? 8'(OUT_MAX) : adapt[7:0];
          send_val = 1'b1;
        end else begin
          c1n = sreg[SU_FIX +: 8];
          send_val = 1'b1;
        end
      end
      PH_SDIM: begin
        if (brightness >= setp) begin
          r_next.tel.valid = 1'b1;
          r_next.tel.kind  = TK_DIM;
          r_next.tel.dim   = 4'h0;
          r_next.timer     = r_reg.cfg[R_WAIT][15:0];
          r_next.phase     = PH_WAIT;
        end else if (tmo) begin
          r_next.tel.valid = 1'b1;
          r_next.tel.kind  = TK_DIM;
          r_next.tel.dim   = {1'b1, sreg[SU_STEP +: 3]};
          r_next.timer     = 16'(sreg[SU_REP +: 8]);
        end
      end
      PH_WAIT: begin
        if (tmo) r_next.phase = PH_MAIN;
      end
      PH_MAIN: begin
        if (tmo) begin
          if ({1'b0, brightness} < lo && r_reg.c1 != 8'hff) begin
            c1n = (9'(r_reg.c1) + 9'(step) > 9'(OUT_MAX)) ? 8'hff :
                  8'(r_reg.c1 + step);
            send_val = 1'b1;
          end else if ({1'b0, brightness} > hi) begin
            if (ctrl[CT_LLEN] && r_reg.c1 <= llim) begin
              if (ctrl[CT_OFF] && {2'b00, brightness} >= offb) begin
                c1n = 8'h00;
                r_next.phase = PH_OFF;
                if (multi) begin
                  send_val = 1'b1;
                end else begin
                  r_next.tel.valid = 1'b1;
                  r_next.tel.kind  = TK_SWITCH;
                  r_next.tel.on    = 1'b0;
                  r_next.tel.chans = 3'b001;
                end
              end
            end else if (r_reg.c1 > floor_v) begin
              c1n = (r_reg.c1 > 8'(floor_v + step)) ?
                    8'(r_reg.c1 - step) : floor_v;
              send_val = 1'b1;
            end
          end
          if (send_val || r_next.tel.valid)
            r_next.timer = 16'(mreg[MN_REP +: 8]);
        end
      end
      PH_OFF: begin
        if ({1'b0, brightness} < lo) r_next.phase = PH_EVAL;
      end
      default: r_next.phase = PH_IDLE;
    endcase
    // ---- channel derivation and telegram build
    n2 = derive(c1n, ctrl[CT_DECR], r_reg.cfg[R_CH2],
                r_reg.cfg[R_ONOFF][7:0], r_reg.d2);
    n3 = derive(c1n, ctrl[CT_DECR], r_reg.cfg[R_CH3],
                r_reg.cfg[R_ONOFF][7:0], r_reg.d3);
    r_next.c1 = c1n;
    if (send_val) begin
      r_next.d2 = n2;
      r_next.d3 = n3;
      r_next.tel.valid = 1'b1;
      r_next.tel.chans = chmask;
      r_next.tel.v1    = c1n;
      r_next.tel.v2    = chmask[1] ? n2.out : 8'h00;
      r_next.tel.v3    = chmask[2] ? n3.out : 8'h00;
      // relative format only with one channel and in main phase
      if (ctrl[CT_REL] && !multi && r_reg.phase == PH_MAIN &&
          c1n != 8'h00) begin
        r_next.tel.kind = TK_DIM;
        r_next.tel.dim  = {c1n > r_reg.c1, mreg[MN_REL +: 3]};
      end else begin
        r_next.tel.kind = TK_VALUE;
      end
    end
    if (!ctrl[CT_EN]) r_next.phase = PH_IDLE;
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      r_reg         <= '0;
      r_reg.phase   <= PH_IDLE;
      r_reg.waitreq <= 1'b1;
      r_reg.cfg     <= CFG_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign avs_waitrequest = r_reg.waitreq;
  assign avs_readdata    = r_reg.rdata;
  assign tel             = r_reg.tel;

endmodule : mlc_ctrl

// [tb/mlc_ctrl_chk.sv]
// checker: port assertions of the light controller
`timescale 1ns/10ps
module mlc_ctrl_chk (
  input wire logic              clk,
  input wire logic              nrst,
  input wire mlc_pkg::mlc_avs_t avs_req,
  input wire logic              avs_waitrequest,
  input wire logic [31:0]       avs_readdata,
  input wire logic [15:0]       brightness,
  input wire mlc_pkg::mlc_tel_t tel
);
  import mlc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ==========================================================================
  // shadows of the settings, taken at the completing edge of a write
  logic [31:0] ctrl_reg;
  logic [31:0] ch2_reg;
  logic        wdone;
  logic [1:0]  nch;
  logic        vt;
  assign wdone = avs_req.write && !avs_waitrequest;
  assign nch   = ctrl_reg[2:1];
  assign vt    = tel.valid && tel.kind == TK_VALUE;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_reg <= CFG_RST[R_CTRL];
      ch2_reg  <= CFG_RST[R_CH2];
    end else if (wdone && avs_req.address == 6'h00)
      ctrl_reg <= avs_req.writedata & CFG_MASK[R_CTRL];
    else if (wdone && avs_req.address == 6'h18)
      ch2_reg <= avs_req.writedata & CFG_MASK[R_CH2];
  end
  // ==========================================================================
  // properties
  property p_wait_one;
    (avs_req.read || avs_req.write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest not low for one cycle");
  property p_unmapped;
    avs_req.read && !avs_waitrequest
      && (avs_req.address > 6'h2c || avs_req.address[1:0] != 2'h0)
      |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_one_ch;
    tel.valid && nch == 2'd1
      |-> tel.chans == 3'b001 && tel.v2 == 8'h0 && tel.v3 == 8'h0;
  endproperty
  a_one_ch: assert property (p_one_ch)
    else $error("single channel telegram touches derived channels");
  property p_multi_abs;
    tel.valid && nch > 2'd1 |-> tel.kind == TK_VALUE;
  endproperty
  a_multi_abs: assert property (p_multi_abs)
    else $error("multichannel telegram not absolute");
  property p_zero;
    vt && tel.v1 == 8'h0 |-> tel.v2 == 8'h0 && tel.v3 == 8'h0;
  endproperty
  a_zero: assert property (p_zero)
    else $error("derived channel on while channel one off");
  property p_pct;
    vt && nch > 2'd1 && !ctrl_reg[6]
      |-> (ch2_reg[7:0] < 8'd100 || tel.v2 >= tel.v1)
       && (ch2_reg[7:0] > 8'd100 || tel.v2 <= tel.v1);
  endproperty
  a_pct: assert property (p_pct)
    else $error("percentage scaling on wrong side");
  property p_cap;
    vt && nch > 2'd1 && !ctrl_reg[6]
      && 16'(tel.v1) * 16'(ch2_reg[7:0]) >= 16'd25450 |-> tel.v2 == 8'hff;
  endproperty
  a_cap: assert property (p_cap)
    else $error("derived output not capped");
  property p_sync;
    vt && nch > 2'd1 && ctrl_reg[6] && !ch2_reg[15] && tel.v1 != 8'h0
      && tel.v1 >= ch2_reg[23:16] |-> tel.v2 == tel.v1;
  endproperty
  a_sync: assert property (p_sync)
    else $error("offset not zero above sync output");
  property p_hold;
    !tel.valid |-> $stable({tel.kind, tel.chans, tel.on, tel.dim,
                            tel.v1, tel.v2, tel.v3});
  endproperty
  a_hold: assert property (p_hold)
    else $error("telegram fields moved without a telegram");
  c_stop: cover property (tel.valid && tel.kind == TK_DIM && tel.dim == 4'h0);
  c_off: cover property (tel.valid && tel.kind == TK_SWITCH && !tel.on);
  c_multi: cover property (vt && nch == 2'd3);
endmodule : mlc_ctrl_chk

bind mlc_ctrl mlc_ctrl_chk mlc_ctrl_chk_inst (
  .clk(clk), .nrst(nrst), .avs_req(avs_req),
  .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
  .brightness(brightness), .tel(tel));

// [tb/mlc_dimmer.sv]
// partner model: dimmer actuator turning telegrams into room brightness
`timescale 1ns/10ps
module mlc_dimmer #(
  parameter int LUX_STEP = 2  // lux per output step, arbitrary lamp
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire mlc_pkg::mlc_tel_t tel,
  input  wire logic [15:0]       daylight,
  output logic [15:0]            brightness
);
  import mlc_pkg::*;
  logic [8:0] level_reg;
  logic [8:0] up;
  // one step up per increase telegram, decrease ignored: a real lamp ramps, this one jumps at once
  assign up = level_reg + (9'h0ff >> (tel.dim[2:0] - 3'h1));
  always_ff @(posedge clk) begin
    if (!nrst)
      level_reg <= 9'h0;
    else if (tel.valid) begin
      case (tel.kind)
        TK_SWITCH: level_reg <= tel.on ? 9'h0ff : 9'h0;
        TK_DIM: if (tel.dim[3] && tel.dim[2:0] != 3'h0)
          level_reg <= (up > 9'h0ff) ? 9'h0ff : up;
        default: level_reg <= {1'b0, tel.v1};
      endcase
    end
  end
  assign brightness = daylight + 16'(level_reg) * 16'(LUX_STEP);
endmodule : mlc_dimmer

// [tb/tb_mlc_ctrl.sv]
// testbench: scenarios of the multichannel light controller
`timescale 1ns/10ps
module tb_mlc_ctrl;
  import mlc_pkg::*;
  // ==========================================================================
  // wiring
  localparam int TK = 4;  // short tick keeps configured times cheap
  logic        clk;
  logic        nrst;
  mlc_avs_t    req;
  logic        avs_waitrequest;
  logic [31:0] avs_readdata;
  logic [15:0] brightness;
  logic [15:0] daylight;
  mlc_tel_t    tel;
  mlc_tel_t    got;
  logic        seen;
  int          cyc;
  int          mismatches;
  int          total_checks;
  mlc_ctrl #(.TICK_CYCLES(TK)) mlc_ctrl_inst (.clk(clk), .nrst(nrst),
    .avs_req(req), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .brightness(brightness), .tel(tel));
  mlc_dimmer mlc_dimmer_inst (.clk(clk), .nrst(nrst), .tel(tel),
    .daylight(daylight), .brightness(brightness));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // ==========================================================================
  // helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{read: 1'b0, write: 1'b1, address: a, writedata: d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    req.write <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] d;
    @(posedge clk);
    req <= '{read: 1'b1, write: 1'b0, address: a, writedata: 32'h0};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    req.read <= 1'b0;
    chk(d & m, e);
  endtask : rd_chk
  task automatic wait_tel(input int n);
    seen = 1'b0;
    for (int i = 0; i < n && !seen; i++) begin
      @(posedge clk);
      if (tel.valid === 1'b1) begin
        got = tel;
        seen = 1'b1;
      end
    end
  endtask : wait_tel
  task automatic cfg(input logic [31:0] sp, st, wt, mn, c2, c3);
    @(posedge clk);
    nrst <= 1'b0;
    daylight <= 16'h0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    wr(6'h04, sp);
    wr(6'h0c, st);
    wr(6'h10, wt);
    wr(6'h14, mn);
    wr(6'h18, c2);
    wr(6'h1c, c3);
  endtask : cfg
  function automatic logic [31:0] ph(input mlc_phase_t p);
    return {5'h0, p, 24'h0};
  endfunction : ph
  function automatic logic [7:0] pct(input int v, input int p);
    int r;
    r = (v * p + 50) / 100;
    return 8'((r > 255) ? 255 : r);
  endfunction : pct
  // start offset s, sync output 200, rounded to nearest
  function automatic logic [7:0] dec(input int v, input int s);
    int o;
    o = s * (200 - v);
    o = (o + (o < 0 ? -99 : 99)) / 199;
    if (v >= 200)
      o = 0;
    o = v + o;
    if (v == 0)
      o = 0;
    return 8'((o < 0) ? 0 : ((o > 255) ? 255 : o));
  endfunction : dec
  // ==========================================================================
  // scenarios
  task automatic t_regs;
    rd_chk(6'h00, '1, 32'h2);
    rd_chk(6'h18, '1, 32'h64);
    rd_chk(6'h1c, '1, 32'h64);
    wr(6'h08, 32'hffffffff);
    rd_chk(6'h08, '1, 32'h0000ffff);
    wr(6'h28, 32'hffffffff);
    rd_chk(6'h28, '1, 32'h0);
    rd_chk(6'h30, '1, 32'h0);
    rd_chk(6'h05, '1, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_switch;
    cfg(32'd200, 32'h0, 32'd5, 32'h0105, 32'h64, 32'h64);
    wr(6'h00, 32'h3);
    wait_tel(20);
    chk({seen, got.kind, got.chans, got.on},
        {1'b1, TK_SWITCH, 4'h3});
    repeat (8) @(posedge clk);
    rd_chk(6'h28, 32'h07000000, ph(PH_WAIT));
    repeat (30) @(posedge clk);
    rd_chk(6'h28, 32'h07000000, ph(PH_MAIN));
    cfg(32'd200, 32'h0, 32'd5, 32'h0105, 32'h64, 32'h64);
    daylight <= 16'd300;
    wr(6'h00, 32'h3);
    repeat (3) @(posedge clk);
    rd_chk(6'h28, 32'h07000000, ph(PH_MAIN));
    // adaptive: 255 * 200 / 400 rounds to 128
    cfg(32'd200, 32'h0, 32'd5, 32'h0105, 32'h64, 32'h64);
    wr(6'h24, 32'd400);
    wr(6'h00, 32'h1b);
    wait_tel(20);
    chk({seen, got.kind, got.v1}, {1'b1, TK_VALUE, 8'd128});
    $display("test switch done");
  endtask : t_switch
  task automatic t_dim;
    cfg(32'd200, 32'h00020300, 32'hff, 32'h0105, 32'h64, 32'h64);
    wr(6'h00, 32'hb);
    for (int i = 0; i < 3; i++) begin
      wait_tel(20);
      chk({seen, got.kind, got.dim},
          {1'b1, TK_DIM, i < 2 ? 4'hb : 4'h0});
    end
    $display("test dim done");
  endtask : t_dim
  task automatic t_pct;
    int vals[2] = '{200, 20};
    foreach (vals[i]) begin
      cfg(32'd200, 32'(vals[i]), 32'hff, 32'h0105, 32'd160, 32'd80);
      wr(6'h00, 32'h7);
      wait_tel(20);
      chk({seen, got.kind, got.chans},
          {1'b1, TK_VALUE, 3'h7});
      chk({got.v1, got.v2, got.v3}, {8'(vals[i]), pct(vals[i], 160),
          pct(vals[i], 80)});
    end
    $display("test percent done");
  endtask : t_pct
  task automatic t_decr;
    int vals[5] = '{180, 60, 220, 1, 0};
    foreach (vals[i]) begin
      cfg(32'd200, 32'(vals[i]), 32'hff, 32'h0105, 32'h00c83264,
          32'h00c8ce64);
      wr(6'h00, 32'h57);
      wait_tel(20);
      chk({seen, got.v1, got.v2, got.v3}, {1'b1, 8'(vals[i]),
          dec(vals[i], 50), dec(vals[i], -50)});
    end
    $display("test decreasing done");
  endtask : t_decr
  task automatic t_main;
    int         t0;
    logic [7:0] v0;
    // small step 5, repeat 3 ticks, as recommended
    cfg(32'd1000, 32'd10, 32'd0, 32'h0305, 32'h64, 32'h64);
    wr(6'h00, 32'h13);
    wait_tel(20);
    wait_tel(60);
    v0 = got.v1;
    t0 = cyc;
    wait_tel(60);
    chk({seen, got.kind}, {1'b1, TK_VALUE});
    chk(32'(cyc - t0 >= 9), 32'h1);
    chk(32'({1'b0, got.v1} >= {1'b0, v0} + 9'd5), 32'h1);
    cfg(32'd1000, 32'd10, 32'd0, 32'h04000305, 32'h64, 32'h64);
    wr(6'h00, 32'h33);
    wait_tel(20);
    wait_tel(60);
    chk({seen, got.kind, got.dim[3]}, {1'b1, TK_DIM, 1'b1});
    $display("test main done");
  endtask : t_main
  task automatic t_off;
    cfg(32'd300, 32'd10, 32'd2, 32'h000a0105, 32'h64, 32'h64);
    wr(6'h08, 32'h0a0a);
    wr(6'h00, 32'h193);
    wait_tel(20);
    daylight <= 16'd339;
    repeat (40) @(posedge clk);
    rd_chk(6'h28, 32'h07000000, ph(PH_MAIN));
    daylight <= 16'd340;
    wait_tel(40);
    chk({seen, got.kind, got.on}, {1'b1, TK_SWITCH, 1'b0});
    rd_chk(6'h28, 32'h07000000, ph(PH_OFF));
    $display("test switch-off done");
  endtask : t_off
  // ==========================================================================
  // sequence and verdict
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  initial begin
    nrst = 1'b0;
    req = '0;
    daylight = 16'h0;
    cyc = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_switch;
    t_dim;
    t_pct;
    t_decr;
    t_main;
    t_off;
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out;
  end
endmodule : tb_mlc_ctrl
